// file: design/bcsr_pkg.sv
package bcsr_pkg;

    // register byte addresses in the upper onboard device region
    localparam logic [31:0] BCSR_ADDR_BOARD_IDENTITY  = 32'hffe0_0010;
    localparam logic [31:0] BCSR_ADDR_COMPAT_LEVEL    = 32'hffe0_0012;
    localparam logic [31:0] BCSR_ADDR_MEM_CONFIG      = 32'hffe0_0014;
    localparam logic [31:0] BCSR_ADDR_FLASH_PAGE      = 32'hffe0_0016;
    localparam logic [31:0] BCSR_ADDR_WDOG_CONTROL    = 32'hffe0_0018;
    localparam logic [31:0] BCSR_ADDR_BOARD_CONTROL   = 32'hffe0_001a;
    localparam logic [31:0] BCSR_ADDR_CAUSE_FLAGS     = 32'hffe0_001c;
    localparam logic [31:0] BCSR_ADDR_LOGIC_REVISION  = 32'hffe0_001e;

    // memory_config_status fields
    localparam int BCSR_MEM_SIZE_LO_POS    = 0;
    localparam int BCSR_ECC_ENABLED_POS    = 4;
    localparam int BCSR_BOOT_JUMPER_POS    = 7;

    // watchdog_control fields
    localparam int BCSR_WDOG_PERIOD_LO_POS = 0;
    localparam int BCSR_WDOG_PERIOD_HI_POS = 1;
    localparam int BCSR_WDOG_RETRIGGER_POS = 4;
    localparam int BCSR_WDOG_CASCADE_POS   = 5;
    localparam int BCSR_WDOG_ROUTE_POS     = 6;
    localparam int BCSR_WDOG_ENABLE_POS    = 7;

    // board_control fields
    localparam int BCSR_GREEN_POS          = 0;
    localparam int BCSR_RED_POS            = 1;
    localparam int BCSR_SOFT_RESET_POS     = 4;
    localparam int BCSR_SERIAL_SEL_POS     = 7;

    // interrupt_cause_flags fields
    localparam int BCSR_WDOG_FLAG_POS      = 0;
    localparam int BCSR_ABORT_FLAG_POS     = 2;

    // identity values: arbitrary neutral codes
    localparam logic [7:0] BCSR_BOARD_CODE_DEF   = 8'h5a;
    localparam logic [7:0] BCSR_COMPAT_LEVEL_DEF = 8'h00;
    localparam logic [7:0] BCSR_REVISION_DEF     = 8'h00;

    // reset values
    localparam logic [3:0] BCSR_FLASH_PAGE_RST = 4'h0;
    localparam logic [7:0] BCSR_RDATA_RST      = 8'h00;

    // watchdog timing: periods are 1..4 units of half a second
    localparam int unsigned BCSR_CLK_HZ        = 40_000_000;
    localparam int unsigned BCSR_WDOG_UNIT_MS  = 500;
    localparam int unsigned BCSR_WDOG_UNIT_CYC = BCSR_CLK_HZ / 1000 * BCSR_WDOG_UNIT_MS;
    localparam int          BCSR_PRESC_W       = 25;
    localparam int          BCSR_UNITS_W       = 3;

    typedef enum logic [2:0] {
        WD_OFF  = 3'b001,
        WD_RUN  = 3'b010,
        WD_CASC = 3'b100
    } bcsr_wd_phase_t;

    typedef struct packed {
        logic [7:0]              rdata;
        logic                    green;
        logic                    red;
        logic                    serial_sel;
        logic [3:0]              flash_page;
        bcsr_wd_phase_t          wd_phase;
        logic                    wd_active;
        logic                    wd_route;
        logic                    wd_cascade;
        logic [1:0]              wd_period;
        logic [BCSR_UNITS_W-1:0] wd_units;
        logic [BCSR_PRESC_W-1:0] wd_presc;
        logic                    ev_wdog;
        logic                    ev_abort;
        logic                    abort_prev;
        logic                    nmi;
        logic                    sys_rst;
    } bcsr_state_t;

    localparam bcsr_state_t BCSR_STATE_RST = '{
        rdata:      BCSR_RDATA_RST,
        flash_page: BCSR_FLASH_PAGE_RST,
        wd_phase:   WD_OFF,
        default:    '0
    };

    typedef struct packed {
        logic [1:0] mem_size;
        logic       ecc_en;
        logic       boot_jumper;
        logic       abort;
    } bcsr_pins_t;

endpackage : bcsr_pkg

// file: design/bcsr_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module bcsr_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule : bcsr_sync2

`default_nettype wire

// file: design/bcsr_regs.sv
`timescale 1ns/100ps
`default_nettype none

module bcsr_regs
    import bcsr_pkg::*;
#(
    parameter int unsigned WDOG_UNIT_CYC = BCSR_WDOG_UNIT_CYC
) (
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic        CS_IN,
    input  wire logic        RD_IN,
    input  wire logic        WR_IN,
    input  wire logic [31:0] ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic [1:0]  MEM_SIZE_IN,
    input  wire logic        ECC_EN_IN,
    input  wire logic        BOOT_JUMPER_IN,
    input  wire logic        ABORT_BUTTON_IN,
    output var  logic [7:0]  RDATA_OUT,
    output var  logic [3:0]  FLASH_PAGE_OUT,
    output var  logic        GREEN_LED_OUT,
    output var  logic        RED_LED_OUT,
    output var  logic        WDOG_ACTIVE_OUT,
    output var  logic        SERIAL_LINE_SEL_OUT,
    output var  logic        NMI_OUT,
    output var  logic        SYS_RESET_OUT
);

    bcsr_state_t q;
    bcsr_state_t d;
    bcsr_pins_t  pins_raw;
    bcsr_pins_t  pins;

    logic        rd_en;
    logic        wr_en;
    logic        unit_tick;
    logic        timeout;
    logic        retrig;
    logic [7:0]  rmux;
    logic [7:0]  wdog_rd;
    logic [7:0]  ctrl_rd;
    logic [7:0]  flags_rd;
    logic [7:0]  mem_rd;

    assign pins_raw.mem_size    = MEM_SIZE_IN;
    assign pins_raw.ecc_en      = ECC_EN_IN;
    assign pins_raw.boot_jumper = BOOT_JUMPER_IN;
    assign pins_raw.abort       = ABORT_BUTTON_IN;

    // board pins come from outside the clock domain
    bcsr_sync2 #(
        .W      ($bits(bcsr_pins_t))
    ) u_pin_sync (
        .clk_in (CLK_IN),
        .nrst_in(NRST_IN),
        .d_in   (pins_raw),
        .q_out  (pins)
    );

    // read-back images of the registers
    always_comb begin
        mem_rd                          = 8'h00;
        mem_rd[BCSR_MEM_SIZE_LO_POS+:2] = pins.mem_size;
        mem_rd[BCSR_ECC_ENABLED_POS]    = pins.ecc_en;
        mem_rd[BCSR_BOOT_JUMPER_POS]    = pins.boot_jumper;

        wdog_rd                            = 8'h00;
        wdog_rd[BCSR_WDOG_PERIOD_LO_POS]   = q.wd_period[0];
        wdog_rd[BCSR_WDOG_PERIOD_HI_POS]   = q.wd_period[1];
        wdog_rd[BCSR_WDOG_RETRIGGER_POS]   = 1'b0;
        wdog_rd[BCSR_WDOG_CASCADE_POS]     = q.wd_cascade;
        wdog_rd[BCSR_WDOG_ROUTE_POS]       = q.wd_route;
        wdog_rd[BCSR_WDOG_ENABLE_POS]      = q.wd_active;

        ctrl_rd                       = 8'h00;
        ctrl_rd[BCSR_GREEN_POS]       = q.green;
        ctrl_rd[BCSR_RED_POS]         = q.red;
        ctrl_rd[BCSR_SERIAL_SEL_POS]  = q.serial_sel;

        flags_rd                       = 8'h00;
        flags_rd[BCSR_WDOG_FLAG_POS]   = q.ev_wdog;
        flags_rd[BCSR_ABORT_FLAG_POS]  = q.ev_abort;
    end

    always_comb begin
        unique case (ADDR_IN)
            BCSR_ADDR_BOARD_IDENTITY: rmux = BCSR_BOARD_CODE_DEF;
            BCSR_ADDR_COMPAT_LEVEL:   rmux = BCSR_COMPAT_LEVEL_DEF;
            BCSR_ADDR_MEM_CONFIG:     rmux = mem_rd;
            BCSR_ADDR_FLASH_PAGE:     rmux = {4'h0, q.flash_page};
            BCSR_ADDR_WDOG_CONTROL:   rmux = wdog_rd;
            BCSR_ADDR_BOARD_CONTROL:  rmux = ctrl_rd;
            BCSR_ADDR_CAUSE_FLAGS:    rmux = flags_rd;
            BCSR_ADDR_LOGIC_REVISION: rmux = BCSR_REVISION_DEF;
            default:                  rmux = 8'h00;
        endcase
    end

    // each write strobe carries one byte
    assign rd_en = CS_IN & RD_IN;
    assign wr_en = CS_IN & WR_IN;

    // half-second units from the board clock
    assign unit_tick = (q.wd_presc == BCSR_PRESC_W'(WDOG_UNIT_CYC - 1));
    assign timeout   = (q.wd_phase != WD_OFF) && unit_tick
                       && (q.wd_units == BCSR_UNITS_W'(1));
    assign retrig    = wr_en && (ADDR_IN == BCSR_ADDR_WDOG_CONTROL)
                       && WDATA_IN[BCSR_WDOG_RETRIGGER_POS];

    always_comb begin
        d         = q;
        d.nmi     = 1'b0;
        d.sys_rst = 1'b0;

        if (rd_en) begin
            d.rdata = rmux;
        end

        // watchdog countdown
        if (q.wd_phase != WD_OFF) begin
            if (unit_tick) begin
                d.wd_presc = '0;
                d.wd_units = q.wd_units - BCSR_UNITS_W'(1);
            end else begin
                d.wd_presc = q.wd_presc + BCSR_PRESC_W'(1);
            end
        end

        if (timeout) begin
            d.wd_presc = '0;
            d.wd_units = BCSR_UNITS_W'({1'b0, q.wd_period}) + BCSR_UNITS_W'(1);
            unique case (q.wd_phase)
                WD_RUN: begin
                    if (q.wd_cascade) begin
                        d.nmi      = 1'b1;
                        d.wd_phase = WD_CASC;
                    end else if (q.wd_route) begin
                        d.nmi = 1'b1;
                    end else begin
                        d.sys_rst = 1'b1;
                    end
                end
                WD_CASC: begin
                    d.sys_rst = 1'b1;
                end
                default: begin
                    d.sys_rst = 1'b0;
                end
            endcase
        end

        if (wr_en) begin
            unique case (ADDR_IN)
                BCSR_ADDR_FLASH_PAGE: begin
                    d.flash_page = WDATA_IN[3:0];
                end
                BCSR_ADDR_WDOG_CONTROL: begin
                    if (q.wd_phase == WD_OFF) begin
                        d.wd_period  = WDATA_IN[BCSR_WDOG_PERIOD_HI_POS:BCSR_WDOG_PERIOD_LO_POS];
                        d.wd_route   = WDATA_IN[BCSR_WDOG_ROUTE_POS];
                        d.wd_cascade = WDATA_IN[BCSR_WDOG_CASCADE_POS];
                        if (WDATA_IN[BCSR_WDOG_ENABLE_POS]) begin
                            d.wd_phase  = WD_RUN;
                            d.wd_active = 1'b1;
                            d.wd_presc  = '0;
                            d.wd_units  = BCSR_UNITS_W'({1'b0, WDATA_IN[1:0]})
                                          + BCSR_UNITS_W'(1);
                        end
                    end else if (retrig) begin
                        d.wd_phase = WD_RUN;
                        d.wd_presc = '0;
                        d.wd_units = BCSR_UNITS_W'({1'b0, q.wd_period}) + BCSR_UNITS_W'(1);
                    end
                end
                BCSR_ADDR_BOARD_CONTROL: begin
                    d.green      = WDATA_IN[BCSR_GREEN_POS];
                    d.red        = WDATA_IN[BCSR_RED_POS];
                    d.serial_sel = WDATA_IN[BCSR_SERIAL_SEL_POS];
                    if (WDATA_IN[BCSR_SOFT_RESET_POS]) begin
                        d.sys_rst = 1'b1;
                    end
                end
                BCSR_ADDR_CAUSE_FLAGS: begin
                    if (WDATA_IN[BCSR_WDOG_FLAG_POS]) begin
                        d.ev_wdog = 1'b0;
                    end
                    if (WDATA_IN[BCSR_ABORT_FLAG_POS]) begin
                        d.ev_abort = 1'b0;
                    end
                end
                default: begin
                    d.flash_page = q.flash_page;
                end
            endcase
        end

        // abort press edge raises nmi
        d.abort_prev = pins.abort;
        if (pins.abort && !q.abort_prev) begin
            d.nmi = 1'b1;
        end

        // events set, winning over a clear
        if (timeout) begin
            d.ev_wdog = 1'b1;
        end
        if (pins.abort && !q.abort_prev) begin
            d.ev_abort = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            q <= BCSR_STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign RDATA_OUT           = q.rdata;
    assign FLASH_PAGE_OUT      = q.flash_page;
    assign GREEN_LED_OUT       = q.green;
    assign RED_LED_OUT         = q.red;
    assign WDOG_ACTIVE_OUT     = q.wd_active;
    assign SERIAL_LINE_SEL_OUT = q.serial_sel;
    assign NMI_OUT             = q.nmi;
    assign SYS_RESET_OUT       = q.sys_rst;

endmodule : bcsr_regs

`default_nettype wire

// file: test/bcsr_regs_props.sv
`timescale 1ns/100ps
`default_nettype none

module bcsr_regs_props
    import bcsr_pkg::*;
(
    input wire logic        CLK_IN,
    input wire logic        NRST_IN,
    input wire logic        CS_IN,
    input wire logic        RD_IN,
    input wire logic        WR_IN,
    input wire logic [31:0] ADDR_IN,
    input wire logic [7:0]  WDATA_IN,
    input wire logic [7:0]  RDATA_OUT,
    input wire logic [3:0]  FLASH_PAGE_OUT,
    input wire logic        GREEN_LED_OUT,
    input wire logic        RED_LED_OUT,
    input wire logic        WDOG_ACTIVE_OUT,
    input wire logic        SERIAL_LINE_SEL_OUT,
    input wire logic        SYS_RESET_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    sequence rd_at(logic [31:0] a);
        CS_IN && RD_IN && ADDR_IN == a;
    endsequence

    sequence wr_at(logic [31:0] a);
        CS_IN && WR_IN && ADDR_IN == a;
    endsequence

    board_code_a: assert property (
        rd_at(BCSR_ADDR_BOARD_IDENTITY) |=> RDATA_OUT == BCSR_BOARD_CODE_DEF)
        else $error("board code read wrong");
    compat_zero_a: assert property (
        rd_at(BCSR_ADDR_COMPAT_LEVEL) |=> RDATA_OUT == 8'h00)
        else $error("compat level read wrong");
    retrig_reads_zero_a: assert property (
        rd_at(BCSR_ADDR_WDOG_CONTROL) |=> !RDATA_OUT[4])
        else $error("retrigger bit read as one");
    flash_write_a: assert property (
        wr_at(BCSR_ADDR_FLASH_PAGE) |=> FLASH_PAGE_OUT == $past(WDATA_IN[3:0]))
        else $error("flash page not written");
    flash_hold_a: assert property (
        !(CS_IN && WR_IN && ADDR_IN == BCSR_ADDR_FLASH_PAGE) |=> $stable(FLASH_PAGE_OUT))
        else $error("flash page changed without write");
    led_write_a: assert property (
        wr_at(BCSR_ADDR_BOARD_CONTROL) |=> {RED_LED_OUT, GREEN_LED_OUT} == $past(WDATA_IN[1:0]))
        else $error("indicators not written");
    serial_sel_a: assert property (
        wr_at(BCSR_ADDR_BOARD_CONTROL) |=> SERIAL_LINE_SEL_OUT == $past(WDATA_IN[7]))
        else $error("serial select not written");
    soft_reset_a: assert property (
        wr_at(BCSR_ADDR_BOARD_CONTROL) ##0 WDATA_IN[4] |=> SYS_RESET_OUT)
        else $error("soft reset not pulsed");
    wdog_on_a: assert property (
        wr_at(BCSR_ADDR_WDOG_CONTROL) ##0 WDATA_IN[7] |=> WDOG_ACTIVE_OUT)
        else $error("watchdog active not raised");
    wdog_stays_a: assert property (
        WDOG_ACTIVE_OUT |=> WDOG_ACTIVE_OUT)
        else $error("watchdog disabled without reset");
endmodule : bcsr_regs_props

bind bcsr_regs bcsr_regs_props props_u (
    .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CS_IN(CS_IN), .RD_IN(RD_IN),
    .WR_IN(WR_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT),
    .FLASH_PAGE_OUT(FLASH_PAGE_OUT), .GREEN_LED_OUT(GREEN_LED_OUT),
    .RED_LED_OUT(RED_LED_OUT), .WDOG_ACTIVE_OUT(WDOG_ACTIVE_OUT),
    .SERIAL_LINE_SEL_OUT(SERIAL_LINE_SEL_OUT), .SYS_RESET_OUT(SYS_RESET_OUT)
);

`default_nettype wire

// file: test/bcsr_regs_test.sv
`timescale 1ns/100ps
`default_nettype none

module bcsr_regs_test
    import bcsr_pkg::*;
;
    localparam int U = 10;

    logic        clk         = 1'b0;
    logic        nrst_n      = 1'b0;
    logic        cs          = 1'b0;
    logic        rd          = 1'b0;
    logic        wr          = 1'b0;
    logic [31:0] addr        = 32'h0000_0000;
    logic [7:0]  wdata       = 8'h00;
    logic [1:0]  mem_size    = 2'h2;
    logic        ecc_en      = 1'b1;
    logic        boot_jumper = 1'b1;
    logic        abort_btn   = 1'b0;
    logic [7:0]  rdata;
    logic [3:0]  flash_page;
    logic        green;
    logic        red;
    logic        wdog_active;
    logic        serial_sel;
    logic        nmi;
    logic        sys_rst;
    int          n_errors    = 0;
    int          check_count = 0;
    int          cycles      = 0;

    bcsr_regs #(.WDOG_UNIT_CYC(U)) dut_u (
        .CLK_IN(clk), .NRST_IN(nrst_n), .CS_IN(cs), .RD_IN(rd), .WR_IN(wr),
        .ADDR_IN(addr), .WDATA_IN(wdata), .MEM_SIZE_IN(mem_size), .ECC_EN_IN(ecc_en),
        .BOOT_JUMPER_IN(boot_jumper), .ABORT_BUTTON_IN(abort_btn), .RDATA_OUT(rdata),
        .FLASH_PAGE_OUT(flash_page), .GREEN_LED_OUT(green), .RED_LED_OUT(red),
        .WDOG_ACTIVE_OUT(wdog_active), .SERIAL_LINE_SEL_OUT(serial_sel),
        .NMI_OUT(nmi), .SYS_RESET_OUT(sys_rst)
    );

    always #12.5 clk = ~clk;

    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_n(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_n

    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        cs <= 1'b1;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        cs <= 1'b0;
        rd <= 1'b0;
        wr <= 1'b0;
        #1;
    endtask : bus

    task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk8(rdata, exp);
    endtask : rd_chk

    // cycles until the wanted pulse; the other pulse first is a failure
    task automatic wait_evt(input logic want_nmi, input int exp);
        int n;
        n = 0;
        while (n < 200 && (want_nmi ? nmi : sys_rst) !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if ((want_nmi ? sys_rst : nmi) === 1'b1) n = 999;
        end
        chk_n(n, exp);
    endtask : wait_evt

    task automatic do_reset();
        @(posedge clk);
        nrst_n <= 1'b0;
        repeat (4) @(posedge clk);
        nrst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    initial begin
        do_reset();
        rd_chk(BCSR_ADDR_BOARD_IDENTITY, BCSR_BOARD_CODE_DEF);
        rd_chk(BCSR_ADDR_COMPAT_LEVEL, 8'h00);
        rd_chk(BCSR_ADDR_FLASH_PAGE, 8'h00);
        rd_chk(BCSR_ADDR_WDOG_CONTROL, 8'h00);
        rd_chk(BCSR_ADDR_BOARD_CONTROL, 8'h00);
        rd_chk(BCSR_ADDR_CAUSE_FLAGS, 8'h00);
        rd_chk(BCSR_ADDR_LOGIC_REVISION, BCSR_REVISION_DEF);
        rd_chk(32'hffe0_0011, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            mem_size <= 2'(i);
            ecc_en <= i[0];
            boot_jumper <= i[1];
            repeat (3) @(posedge clk);
            rd_chk(BCSR_ADDR_MEM_CONFIG, {i[1], 2'b00, i[0], 2'b00, 2'(i)});
        end
        bus(1'b1, BCSR_ADDR_FLASH_PAGE, 8'hff);
        chk8({4'h0, flash_page}, 8'h0f);
        rd_chk(BCSR_ADDR_FLASH_PAGE, 8'h0f);
        bus(1'b1, BCSR_ADDR_BOARD_CONTROL, 8'h13);
        chk8({4'h0, sys_rst, serial_sel, red, green}, 8'h0b);
        @(posedge clk);
        #1;
        chk8({7'h0, sys_rst}, 8'h00);
        bus(1'b1, BCSR_ADDR_BOARD_CONTROL, 8'h80);
        chk8({4'h0, sys_rst, serial_sel, red, green}, 8'h04);
        rd_chk(BCSR_ADDR_BOARD_CONTROL, 8'h80);
        // every period code on the reset route
        for (int p = 0; p < 4; p++) begin
            do_reset();
            bus(1'b1, BCSR_ADDR_WDOG_CONTROL, 8'h80 | 8'(p));
            chk8({7'h0, wdog_active}, 8'h01);
            wait_evt(1'b0, U * (p + 1));
            rd_chk(BCSR_ADDR_CAUSE_FLAGS, 8'h01);
        end
        bus(1'b1, BCSR_ADDR_WDOG_CONTROL, 8'h00);
        rd_chk(BCSR_ADDR_WDOG_CONTROL, 8'h83);
        bus(1'b1, BCSR_ADDR_CAUSE_FLAGS, 8'h01);
        rd_chk(BCSR_ADDR_CAUSE_FLAGS, 8'h00);
        bus(1'b1, BCSR_ADDR_WDOG_CONTROL, 8'h93);
        wait_evt(1'b0, U * 4);
        rd_chk(BCSR_ADDR_WDOG_CONTROL, 8'h83);
        do_reset();
        bus(1'b1, BCSR_ADDR_WDOG_CONTROL, 8'hc1);
        wait_evt(1'b1, U * 2);
        rd_chk(BCSR_ADDR_CAUSE_FLAGS, 8'h01);
        do_reset();
        bus(1'b1, BCSR_ADDR_WDOG_CONTROL, 8'ha0);
        wait_evt(1'b1, U);
        wait_evt(1'b0, U);
        do_reset();
        @(posedge clk);
        abort_btn <= 1'b1;
        #1;
        wait_evt(1'b1, 3);
        rd_chk(BCSR_ADDR_CAUSE_FLAGS, 8'h04);
        rd_chk(BCSR_ADDR_CAUSE_FLAGS, 8'h04);
        bus(1'b1, BCSR_ADDR_CAUSE_FLAGS, 8'h04);
        rd_chk(BCSR_ADDR_CAUSE_FLAGS, 8'h00);
        @(posedge clk);
        abort_btn <= 1'b0;
        give_verdict();
    end
endmodule : bcsr_regs_test

`default_nettype wire
